// [rtcal_pkg.sv]
// Constants for the century and alarm register block
// Assumes an AHB-Lite slave with 32-bit data, one register per aligned word
// Notes on behaviour
// [R1] The century count keeps its value through reset; no reset value is loaded.
// [R2] The encoding select bit chooses binary when 0 and packed decimal when 1.
// [R3] The century count takes writes only while unlocked; reads always work.
// [R4] In decimal form the century holds tens in bits 7:4 and ones in bits 3:0, each 0 to 9.
// [R5] In binary form the century is one unsigned byte from 00h to 63h.
// [R6] Alarm seconds keeps its value through reset and is freely read and written.
// [R7] In decimal form alarm seconds holds tens 0 to 5 high and ones 0 to 9 low.
// [R8] In binary form alarm seconds is one byte from 00h to 3Bh.
// [R9] Alarm hours keeps its value through reset and is freely read and written.
// [R10] In decimal form alarm hours holds tens 0 to 2 high and ones 0 to 9 low.
// [R11] In binary form alarm hours is one byte from 00h to 17h, a 24-hour count.
// [R12] An alarm match can wake the device from sleep by issuing a reset.
// [R13] The alarm fires when current seconds and hours equal the alarm values, same encoding.
`default_nettype none

package rtcal_pkg;
  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  century_count_idx = 8'hE7;
  localparam logic [7:0]  alarm_seconds_idx = 8'hE8;
  localparam logic [7:0]  alarm_hours_idx   = 8'hEA;
  localparam logic [7:0]  control_idx       = 8'hF0;
  localparam logic [7:0]  status_idx        = 8'hF1;
  localparam logic [11:0] century_count_addr = {2'h0, century_count_idx, 2'h0};
  localparam logic [11:0] alarm_seconds_addr = {2'h0, alarm_seconds_idx, 2'h0};
  localparam logic [11:0] alarm_hours_addr   = {2'h0, alarm_hours_idx, 2'h0};
  localparam logic [11:0] control_addr       = {2'h0, control_idx, 2'h0};
  localparam logic [11:0] status_addr        = {2'h0, status_idx, 2'h0};
  // ----------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------
  localparam int          ctl_bcd_bit      = 0;
  localparam int          ctl_lock_bit     = 1;
  localparam int          ctl_alarm_en_bit = 2;
  localparam int          ctl_wake_en_bit  = 3;
  localparam int          sts_match_bit    = 0;
  localparam int          sts_wake_bit     = 1;
  localparam logic [3:0]  control_reset    = 4'h0;
  localparam logic [3:0]  digit_max        = 4'h9;
  // Wake reset pulse length
  localparam int          wake_pulse_ns    = 20;
  localparam int          clock_mhz        = 200;
  localparam int          wake_cycles      = (wake_pulse_ns * clock_mhz + 999) / 1000;
  localparam logic [2:0]  wake_count_init  = 3'(wake_cycles);
  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [0:0]
  {
    bus_idle  = 1'b0,
    bus_write = 1'b1
  } rtcal_bus_type;
endpackage

`default_nettype wire

// [rtcal_cmp_if.sv]
// Interface between register block and alarm comparator
// Assumes both ends share the one clock
`timescale 1ns/1ps
`default_nettype none

interface rtcal_cmp_if;
  logic [7:0] alarm_seconds;
  logic [7:0] alarm_hours;
  logic [7:0] now_seconds;
  logic [7:0] now_hours;
  logic       bcd_mode;
  logic       match;
  modport regs (output alarm_seconds, output alarm_hours, output now_seconds,
                output now_hours, output bcd_mode, input match);
  modport cmp  (input alarm_seconds, input alarm_hours, input now_seconds,
                input now_hours, input bcd_mode, output match);
endinterface

`default_nettype wire

// [rtcal_match.sv]
// Alarm comparator with encoding check
// Assumes current time counters use the same encoding as the alarm values
`timescale 1ns/1ps
`default_nettype none

module rtcal_match
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Compare values
  rtcal_cmp_if.cmp  cmp
);
  function automatic logic digits_ok(input logic [7:0] v);
    digits_ok = (v[7:4] <= rtcal_pkg::digit_max) && (v[3:0] <= rtcal_pkg::digit_max);
  endfunction

  logic same;
  logic last_same;

  // Both sides compared raw in the selected encoding
  assign same = (cmp.now_seconds == cmp.alarm_seconds)
             && (cmp.now_hours == cmp.alarm_hours)
             && (!cmp.bcd_mode
                 || (digits_ok(cmp.now_seconds) && digits_ok(cmp.now_hours))); // [R13]

  // ----------------------------------------------------------------
  // Rising edge of equality gives one event
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_same <= 1'b0;
      cmp.match <= 1'b0;
    end
    else
    begin
      last_same <= same;
      cmp.match <= same && !last_same; // [R13]
    end
  end
endmodule

`default_nettype wire

// [rtcal_regs.sv]
// Century count, alarm seconds and alarm hours registers on AHB-Lite
// Assumes current seconds and hours come from the clock counters in this domain
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rtcal_regs
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Current time
  input  wire logic [7:0]  now_seconds,
  input  wire logic [7:0]  now_hours,
  input  wire logic        sleeping,
  // Alarm events
  output logic             alarm_event,
  output logic             wake_reset
);
  logic                   rst_meta;
  logic                   rst_n;
  rtcal_pkg::rtcal_bus_type state;
  logic [11:0]            wr_addr;
  logic [7:0]             century_count;
  logic [7:0]             alarm_seconds;
  logic [7:0]             alarm_hours;
  logic [3:0]             control;
  logic                   match_seen;
  logic                   wake_seen;
  logic [2:0]             wake_count;
  logic                   take;
  logic                   wr_now;
  logic [7:0]             wbyte;
  logic [31:0]            next_rdata;

  rtcal_cmp_if cmp_bus ();

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  assign take   = hsel && hready && htrans[1];
  assign wr_now = (state == rtcal_pkg::bus_write);
  assign wbyte  = hwdata[7:0];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= rtcal_pkg::bus_idle;
      wr_addr <= 12'h000;
    end
    else
    begin
      if (take && hwrite)
      begin
        state   <= rtcal_pkg::bus_write;
        wr_addr <= haddr;
      end
      else
      begin
        state   <= rtcal_pkg::bus_idle;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Kept registers, no reset
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (wr_now && wr_addr == rtcal_pkg::century_count_addr
        && !control[rtcal_pkg::ctl_lock_bit]) // [R3]
    begin
      century_count <= wbyte; // [R1] [R4] [R5]
    end
  end

  always_ff @(posedge clock)
  begin
    if (wr_now && wr_addr == rtcal_pkg::alarm_seconds_addr)
    begin
      alarm_seconds <= wbyte; // [R6] [R7] [R8]
    end
  end

  always_ff @(posedge clock)
  begin
    if (wr_now && wr_addr == rtcal_pkg::alarm_hours_addr)
    begin
      alarm_hours <= wbyte; // [R9] [R10] [R11]
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control <= rtcal_pkg::control_reset;
    end
    else if (wr_now && wr_addr == rtcal_pkg::control_addr)
    begin
      control <= hwdata[3:0]; // [R2]
    end
  end

  // ----------------------------------------------------------------
  // Alarm comparison
  // ----------------------------------------------------------------
  assign cmp_bus.alarm_seconds = alarm_seconds;
  assign cmp_bus.alarm_hours   = alarm_hours;
  assign cmp_bus.now_seconds   = now_seconds;
  assign cmp_bus.now_hours     = now_hours;
  assign cmp_bus.bcd_mode      = control[rtcal_pkg::ctl_bcd_bit]; // [R2]

  rtcal_match u_match
  (
    .clock (clock),
    .rst_n (rst_n),
    .cmp   (cmp_bus)
  );

  // ----------------------------------------------------------------
  // Sticky status, set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      match_seen <= 1'b0;
      wake_seen  <= 1'b0;
    end
    else
    begin
      if (cmp_bus.match && control[rtcal_pkg::ctl_alarm_en_bit])
      begin
        match_seen <= 1'b1;
      end
      else if (wr_now && wr_addr == rtcal_pkg::status_addr
               && hwdata[rtcal_pkg::sts_match_bit])
      begin
        match_seen <= 1'b0;
      end
      if (wake_count == 3'h0 && cmp_bus.match && sleeping
          && control[rtcal_pkg::ctl_wake_en_bit])
      begin
        wake_seen <= 1'b1;
      end
      else if (wr_now && wr_addr == rtcal_pkg::status_addr
               && hwdata[rtcal_pkg::sts_wake_bit])
      begin
        wake_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_event <= 1'b0;
      wake_reset  <= 1'b0;
      wake_count  <= 3'h0;
    end
    else
    begin
      alarm_event <= cmp_bus.match && control[rtcal_pkg::ctl_alarm_en_bit]; // [R13]
      if (wake_count != 3'h0)
      begin
        wake_count <= wake_count - 3'h1;
        wake_reset <= (wake_count != 3'h1);
      end
      else if (cmp_bus.match && sleeping && control[rtcal_pkg::ctl_wake_en_bit])
      begin
        wake_count <= rtcal_pkg::wake_count_init;
        wake_reset <= 1'b1; // [R12]
      end
      else
      begin
        wake_reset <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (haddr)
      rtcal_pkg::century_count_addr: next_rdata = {24'h000000, century_count};
      rtcal_pkg::alarm_seconds_addr: next_rdata = {24'h000000, alarm_seconds};
      rtcal_pkg::alarm_hours_addr:   next_rdata = {24'h000000, alarm_hours};
      rtcal_pkg::control_addr:       next_rdata = {28'h0000000, control};
      rtcal_pkg::status_addr:        next_rdata = {30'h00000000, wake_seen, match_seen};
      default:                       next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (take && !hwrite)
    begin
      hrdata <= next_rdata;
    end
  end
endmodule

`default_nettype wire

// [rtcal_monitor.sv]
// Assertion checker for the century and alarm register block
// Assumes it is bound to rtcal_regs and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none

module rtcal_monitor
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Time and events
  input wire logic [7:0]  now_seconds,
  input wire logic [7:0]  now_hours,
  input wire logic        sleeping,
  input wire logic        alarm_event,
  input wire logic        wake_reset
);
  logic        rd_q;
  logic [11:0] addr_q;
  wire logic   rd_take = hsel && hready && htrans[1] && !hwrite;
  wire logic   mapped  = addr_q inside {rtcal_pkg::century_count_addr,
    rtcal_pkg::alarm_seconds_addr, rtcal_pkg::alarm_hours_addr,
    rtcal_pkg::control_addr, rtcal_pkg::status_addr};

  // Read data phase tracker
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      rd_q   <= 1'b0;
      addr_q <= 12'h000;
    end
    else
    begin
      rd_q   <= rd_take;
      addr_q <= haddr;
    end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  ready_high_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  event_pulse_a: assert property (alarm_event |=> !alarm_event)
    else $error("alarm event longer than one cycle");
  wake_len_a: assert property ($rose(wake_reset) |-> wake_reset[*4] ##1 !wake_reset)
    else $error("wake pulse length wrong");
  wake_cause_a: assert property ($rose(wake_reset) |->
    $past(sleeping) || $past(sleeping, 2) || $past(sleeping, 3))
    else $error("wake without sleep");
  rd_upper_a: assert property (rd_q |-> hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  rd_unmapped_a: assert property (rd_q && !mapped |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data changed without read");

  cover property (alarm_event);
  cover property ($rose(wake_reset));
  cover property (rd_q && addr_q == rtcal_pkg::century_count_addr);
endmodule

bind rtcal_regs rtcal_monitor mon (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .now_seconds, .now_hours,
  .sleeping, .alarm_event, .wake_reset);

`default_nettype wire

// [testbench.sv]
// Self-checking bench for the century and alarm register block
// Assumes rtcal_regs is the only slave, so hreadyout feeds hready
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        alarm_event;
  logic        wake_reset;
  logic [7:0]  now_seconds = 8'hFF;
  logic [7:0]  now_hours = 8'hFF;
  logic        sleeping = 1'b0;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n_ev = 0;
  int          n_wk = 0;
  int          e0;
  int          w0;
  logic [7:0]  rnd = 8'h25;
  logic [7:0]  years_hundreds_ones_digit;
  logic [7:0]  sec;
  logic [7:0]  hrs;
  logic [31:0] q;

  rtcal_regs dut (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .now_seconds, .now_hours,
    .sleeping, .alarm_event, .wake_reset);

  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    n_ev += int'(alarm_event === 1'b1);
    n_wk += int'(wake_reset === 1'b1);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] enc(input int v, input int m);
    return (m != 0) ? 8'((v / 10) * 16 + v % 10) : 8'(v);
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    close_out();
  end

  initial
  begin
    do_reset();
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, rtcal_pkg::control_addr, 32'(m));
      for (int i = 0; i < 3; i++)
      begin
        rnd = lfsr(rnd);
        years_hundreds_ones_digit = enc((i == 0) ? 99 : int'(rnd) % 100, m);
        sec = enc((i == 0) ? 59 : int'(rnd) % 60, m);
        hrs = enc((i == 0) ? 23 : int'(rnd) % 24, m);
        bus(1'b1, rtcal_pkg::century_count_addr, {24'h0, years_hundreds_ones_digit});
        bus(1'b1, rtcal_pkg::alarm_seconds_addr, {24'h0, sec});
        bus(1'b1, rtcal_pkg::alarm_hours_addr, {24'h0, hrs});
        bus(1'b0, rtcal_pkg::century_count_addr, 32'h0);
        chk("century", q, {24'h0, years_hundreds_ones_digit});
        bus(1'b0, rtcal_pkg::alarm_seconds_addr, 32'h0);
        chk("alarm_seconds", q, {24'h0, sec});
        bus(1'b0, rtcal_pkg::alarm_hours_addr, 32'h0);
        chk("alarm_hours", q, {24'h0, hrs});
      end
      bus(1'b1, rtcal_pkg::control_addr, 32'(m) | 32'h2);
      bus(1'b1, rtcal_pkg::century_count_addr, {24'h0, ~years_hundreds_ones_digit});
      bus(1'b0, rtcal_pkg::century_count_addr, 32'h0);
      chk("locked century", q, {24'h0, years_hundreds_ones_digit});
      bus(1'b1, rtcal_pkg::control_addr, 32'(m) | 32'hC);
      e0 = n_ev;
      w0 = n_wk;
      now_hours <= hrs;
      now_seconds <= sec ^ 8'h01;
      sleeping <= 1'b1;
      repeat (3) @(posedge clock);
      now_seconds <= sec;
      repeat (10) @(posedge clock);
      now_seconds <= 8'hFF;
      sleeping <= 1'b0;
      chk("alarm events", 32'(n_ev - e0), 32'h1);
      chk("wake cycles", 32'(n_wk - w0), 32'h4);
      bus(1'b0, rtcal_pkg::status_addr, 32'h0);
      chk("status seen", q, 32'h3);
      bus(1'b1, rtcal_pkg::status_addr, 32'h3);
      bus(1'b0, rtcal_pkg::status_addr, 32'h0);
      chk("status cleared", q, 32'h0);
      w0 = n_wk;
      now_seconds <= sec;
      repeat (10) @(posedge clock);
      now_seconds <= 8'hFF;
      chk("no wake while awake", 32'(n_wk - w0), 32'h0);
      $display("mode %0d test done", m);
    end
    do_reset();
    bus(1'b0, rtcal_pkg::control_addr, 32'h0);
    chk("control after reset", q, 32'h0);
    bus(1'b0, rtcal_pkg::century_count_addr, 32'h0);
    chk("kept century", q, {24'h0, years_hundreds_ones_digit});
    bus(1'b0, rtcal_pkg::alarm_seconds_addr, 32'h0);
    chk("kept alarm_seconds", q, {24'h0, sec});
    bus(1'b0, rtcal_pkg::alarm_hours_addr, 32'h0);
    chk("kept alarm_hours", q, {24'h0, hrs});
    bus(1'b1, 12'h004, 32'hFFFFFFFF);
    bus(1'b0, 12'h004, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("reset test done");
    close_out();
  end
endmodule

`default_nettype wire
